/* File: hdl/dhi_host_interface.v */
// Operation
// - Serial frame: 24 bits, MSB first
// - Direction bit one marks a read request
// - Next frame shifts selected register out
// - Readback: request address bits above data
// - Output changes on rising serial clock
// - First readback bit at frame sync fall
// - Two-wire slave only in serial, protocol one
// - Slave address 10101 plus two strap pins
// - Start and stop from SDA while SCL high
// - Acknowledge each byte in ninth clock
// - Writes only; direction bit must be zero
// - Repeated start returns to address recognition
// - Address, pointer, two data bytes, stop
// - Without stop, next byte is new pointer
// - Pointer 0xff starts burst at channel zero
// - Burst advances to 31, then pointer mode
// - No toggle selection in burst writes
// - Register select bits pick the target register
// - Interface select low enables parallel only
// - Write strobe rise latches address and data
// - Parallel word straight binary, top line MSB
`timescale 1ns/1ns
`default_nettype none
`include "dhi_defines.vh"

module dhi_host_interface #(
  parameter CH_W = 5,
  parameter DATA_W = 14
) (
  input wire ref_clk,
  input wire srst,
  input wire interface_select,
  input wire protocol_select,
  input wire sclk,
  input wire sync_n,
  input wire din,
  output reg serial_data_out_r,
  input wire scl,
  input wire sda_in,
  output reg sda_out_r,
  output reg sda_oe_r,
  input wire address_strap_high,
  input wire address_strap_low,
  input wire cs_n,
  input wire wr_n,
  input wire [CH_W-1:0] channel_address,
  input wire register_select_high,
  input wire register_select_low,
  input wire [DATA_W-1:0] data_field,
  output reg rd_req_r,
  output reg [CH_W-1:0] rd_channel_r,
  output reg [1:0] rd_reg_sel_r,
  input wire [DATA_W-1:0] rd_data,
  output reg wr_valid_r,
  output reg wr_toggle_b_r,
  output reg [CH_W-1:0] wr_channel_r,
  output reg [1:0] wr_reg_sel_r,
  output reg [DATA_W-1:0] wr_data_r
);

  localparam SYNC_W = 13 + CH_W + DATA_W;
  localparam ADDR_W = 10;
  localparam RB_W = ADDR_W + DATA_W;

  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_PTR = 3'h2;
  localparam ST_DHI = 3'h3;
  localparam ST_DLO = 3'h4;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  wire [SYNC_W-1:0] pins_s;
  wire iface_s;
  wire proto_s;
  wire sclk_s;
  wire syncn_s;
  wire din_s;
  wire scl_s;
  wire sda_s;
  wire strap_hi_s;
  wire strap_lo_s;
  wire csn_s;
  wire wrn_s;
  wire [CH_W-1:0] ch_s;
  wire [1:0] reg_s;
  wire [DATA_W-1:0] data_s;

  dhi_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in({interface_select, protocol_select, sclk, sync_n, din, scl, sda_in,
               address_strap_high, address_strap_low, cs_n, wr_n,
               register_select_high, register_select_low, channel_address, data_field}),
    .sync_out_r(pins_s)
  );

  assign {iface_s, proto_s, sclk_s, syncn_s, din_s, scl_s, sda_s,
          strap_hi_s, strap_lo_s, csn_s, wrn_s, reg_s, ch_s, data_s} = pins_s;

  //////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised lines

  reg sclk_q_r;
  reg syncn_q_r;
  reg scl_q_r;
  reg sda_q_r;
  reg wrn_q_r;

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      sclk_q_r <= 1'b1;
      syncn_q_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      wrn_q_r <= 1'b1;
    end
    else
    begin
      sclk_q_r <= sclk_s;
      syncn_q_r <= syncn_s;
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
      wrn_q_r <= wrn_s;
    end
  end

  wire spi_en = iface_s & ~proto_s;
  wire i2c_en = iface_s & proto_s;
  wire par_en = ~iface_s;
  wire sclk_fall = sclk_q_r & ~sclk_s;
  wire sclk_rise = ~sclk_q_r & sclk_s;
  wire sync_fall = syncn_q_r & ~syncn_s;
  wire sync_rise = ~syncn_q_r & syncn_s;
  wire scl_rise = ~scl_q_r & scl_s;
  wire scl_fall = scl_q_r & ~scl_s;
  wire i2c_start = scl_q_r & scl_s & sda_q_r & ~sda_s;
  wire i2c_stop = scl_q_r & scl_s & ~sda_q_r & sda_s;
  wire wr_rise = ~wrn_q_r & wrn_s;

  //////////////////////////////////////////////////////////////////////////////
  // State

  reg [`DHI_FRAME_BITS-1:0] spi_sr_r;
  reg [4:0] spi_cnt_r;
  reg rb_pend_r;
  reg rb_active_r;
  reg rb_armed_r;
  reg [ADDR_W-1:0] rb_addr_r;
  reg [RB_W-1:0] rb_sr_r;
  reg [2:0] i2c_st_r;
  reg [3:0] bit_cnt_r;
  reg [7:0] byte_r;
  reg [7:0] hi_r;
  reg burst_r;
  reg [CH_W-1:0] ptr_r;

  wire [6:0] own_addr = {`DHI_I2C_ADDR_FIXED, strap_hi_s, strap_lo_s};
  wire byte_done = (bit_cnt_r == `DHI_I2C_BYTE_BITS);

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      serial_data_out_r <= 1'b0;
      sda_out_r <= 1'b0;
      sda_oe_r <= 1'b0;
      rd_req_r <= 1'b0;
      rd_channel_r <= {CH_W{1'b0}};
      rd_reg_sel_r <= 2'h0;
      wr_valid_r <= 1'b0;
      wr_toggle_b_r <= 1'b0;
      wr_channel_r <= {CH_W{1'b0}};
      wr_reg_sel_r <= 2'h0;
      wr_data_r <= {DATA_W{1'b0}};
      spi_sr_r <= {`DHI_FRAME_BITS{1'b0}};
      spi_cnt_r <= 5'h00;
      rb_pend_r <= 1'b0;
      rb_active_r <= 1'b0;
      rb_armed_r <= 1'b0;
      rb_addr_r <= {ADDR_W{1'b0}};
      rb_sr_r <= {RB_W{1'b0}};
      i2c_st_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      byte_r <= 8'h00;
      hi_r <= 8'h00;
      burst_r <= 1'b0;
      ptr_r <= {CH_W{1'b0}};
    end
    else
    begin
      wr_valid_r <= 1'b0;
      rd_req_r <= 1'b0;

      ////////////////////////////////////////////////////////////////////////////
      // Four-wire serial with readback
      if (!spi_en)
      begin
        spi_cnt_r <= 5'h00;
        rb_pend_r <= 1'b0;
        rb_active_r <= 1'b0;
        serial_data_out_r <= 1'b0;
      end
      else if (sync_fall)
      begin
        spi_cnt_r <= 5'h00;
        rb_armed_r <= 1'b0;
        if (rb_pend_r)
        begin
          rb_pend_r <= 1'b0;
          rb_active_r <= 1'b1;
          rb_sr_r <= {rb_addr_r, rd_data};
          serial_data_out_r <= rb_addr_r[ADDR_W-1];
        end
      end
      else if (sync_rise)
      begin
        // Frame sync bounds the readback; output parks low between frames
        rb_active_r <= 1'b0;
        serial_data_out_r <= 1'b0;
        if (spi_cnt_r == `DHI_FRAME_BITS)
        begin
          if (spi_sr_r[`DHI_FRM_RW])
          begin
            rb_pend_r <= 1'b1;
            rb_addr_r <= spi_sr_r[`DHI_FRM_ADDR_HI:`DHI_FRM_ADDR_LO];
            rd_channel_r <= spi_sr_r[`DHI_FRM_CH_HI:`DHI_FRM_CH_LO];
            rd_reg_sel_r <= spi_sr_r[`DHI_FRM_REG_HI:`DHI_FRM_REG_LO];
            rd_req_r <= 1'b1;
          end
          else
          begin
            wr_valid_r <= 1'b1;
            wr_toggle_b_r <= spi_sr_r[`DHI_FRM_TOGGLE];
            wr_channel_r <= spi_sr_r[`DHI_FRM_CH_HI:`DHI_FRM_CH_LO];
            wr_reg_sel_r <= spi_sr_r[`DHI_FRM_REG_HI:`DHI_FRM_REG_LO];
            wr_data_r <= spi_sr_r[`DHI_FRM_DATA_HI:`DHI_FRM_DATA_LO];
          end
        end
      end
      else if (!syncn_s)
      begin
        // Clocks past the 24th are ignored; short frames are discarded
        if (sclk_fall && spi_cnt_r != `DHI_FRAME_BITS)
        begin
          spi_sr_r <= {spi_sr_r[`DHI_FRAME_BITS-2:0], din_s};
          spi_cnt_r <= spi_cnt_r + 5'h01;
          rb_armed_r <= rb_active_r;
        end
        // A rise before the first fall would skip the MSB, so wait for a fall
        if (sclk_rise && rb_active_r && rb_armed_r)
        begin
          rb_sr_r <= {rb_sr_r[RB_W-2:0], 1'b0};
          serial_data_out_r <= rb_sr_r[RB_W-2];
        end
      end

      ////////////////////////////////////////////////////////////////////////////
      // Two-wire receive-only slave
      sda_out_r <= 1'b0;
      if (!i2c_en)
      begin
        i2c_st_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
        burst_r <= 1'b0;
      end
      else if (i2c_start)
      begin
        i2c_st_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
        burst_r <= 1'b0;
      end
      else if (i2c_stop)
      begin
        i2c_st_r <= ST_IDLE;
        sda_oe_r <= 1'b0;
        burst_r <= 1'b0;
      end
      else
      begin
        if (scl_rise && i2c_st_r != ST_IDLE && !byte_done)
        begin
          byte_r <= {byte_r[6:0], sda_s};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        if (scl_fall)
        begin
          if (sda_oe_r)
          begin
            sda_oe_r <= 1'b0;
            bit_cnt_r <= 4'h0;
          end
          else if (byte_done && i2c_st_r != ST_IDLE)
          begin
            sda_oe_r <= 1'b1;
            case (i2c_st_r)
              ST_ADDR:
              begin
                // A read address or a foreign one is not acknowledged
                if (byte_r[7:1] == own_addr && !byte_r[0])
                begin
                  i2c_st_r <= ST_PTR;
                end
                else
                begin
                  sda_oe_r <= 1'b0;
                  i2c_st_r <= ST_IDLE;
                end
              end
              ST_PTR:
              begin
                i2c_st_r <= ST_DHI;
                if (byte_r == `DHI_I2C_BURST_PTR)
                begin
                  burst_r <= 1'b1;
                  ptr_r <= `DHI_FIRST_CHANNEL;
                end
                else
                begin
                  burst_r <= 1'b0;
                  ptr_r <= byte_r[CH_W-1:0];
                end
              end
              ST_DHI:
              begin
                hi_r <= byte_r;
                i2c_st_r <= ST_DLO;
              end
              ST_DLO:
              begin
                wr_valid_r <= 1'b1;
                wr_toggle_b_r <= 1'b0;
                wr_channel_r <= ptr_r;
                wr_reg_sel_r <= hi_r[`DHI_I2C_REG_HI:`DHI_I2C_REG_LO];
                wr_data_r <= {hi_r[`DHI_I2C_DATA_HI:0], byte_r};
                if (burst_r && ptr_r != `DHI_LAST_CHANNEL)
                begin
                  ptr_r <= ptr_r + {{(CH_W-1){1'b0}}, 1'b1};
                  i2c_st_r <= ST_DHI;
                end
                else
                begin
                  burst_r <= 1'b0;
                  i2c_st_r <= ST_PTR;
                end
              end
              default:
              begin
                sda_oe_r <= 1'b0;
                i2c_st_r <= ST_IDLE;
              end
            endcase
          end
        end
      end

      ////////////////////////////////////////////////////////////////////////////
      // Parallel port; bus passes the same two stages as the strobe
      if (par_en && wr_rise && !csn_s)
      begin
        wr_valid_r <= 1'b1;
        wr_toggle_b_r <= 1'b0;
        wr_channel_r <= ch_s;
        wr_reg_sel_r <= reg_s;
        wr_data_r <= data_s;
      end
    end
  end

endmodule // dhi_host_interface

`default_nettype wire

/* File: hdl/dhi_defines.vh */
`ifndef DHI_DEFINES_VH
`define DHI_DEFINES_VH

// Serial frame layout, MSB first
`define DHI_FRAME_BITS 5'h18
`define DHI_FRM_TOGGLE 23
`define DHI_FRM_RW 22
`define DHI_FRM_CH_HI 20
`define DHI_FRM_CH_LO 16
`define DHI_FRM_REG_HI 15
`define DHI_FRM_REG_LO 14
`define DHI_FRM_DATA_HI 13
`define DHI_FRM_DATA_LO 0
`define DHI_FRM_ADDR_HI 23
`define DHI_FRM_ADDR_LO 14

// Two-wire slave
`define DHI_I2C_ADDR_FIXED 5'h15
`define DHI_I2C_BURST_PTR 8'hff
`define DHI_I2C_BYTE_BITS 4'h8
`define DHI_LAST_CHANNEL 5'h1f
`define DHI_FIRST_CHANNEL 5'h00

// Bit positions inside the first (high) two-wire data byte
`define DHI_I2C_REG_HI 7
`define DHI_I2C_REG_LO 6
`define DHI_I2C_DATA_HI 5

`endif

/* File: hdl/dhi_sync.v */
`timescale 1ns/1ns
`default_nettype none

module dhi_sync #(
  parameter WIDTH = 1
) (
  input wire ref_clk,
  input wire srst,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out_r
);

  reg [WIDTH-1:0] meta_r;

  // Reset to all ones so idle-high lines do not fake an edge at release
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      meta_r <= {WIDTH{1'b1}};
      sync_out_r <= {WIDTH{1'b1}};
    end
    else
    begin
      meta_r <= async_in;
      sync_out_r <= meta_r;
    end
  end

endmodule // dhi_sync

`default_nettype wire

/* File: testbench/dhi_host_interface_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module dhi_host_interface_properties #(
  parameter CH_W = 5,
  parameter DATA_W = 14
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic interface_select,
  input wire logic protocol_select,
  input wire logic sync_n,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic [CH_W-1:0] channel_address,
  input wire logic [DATA_W-1:0] data_field,
  input wire logic serial_data_out_r,
  input wire logic sda_out_r,
  input wire logic sda_oe_r,
  input wire logic rd_req_r,
  input wire logic wr_valid_r,
  input wire logic wr_toggle_b_r,
  input wire logic [CH_W-1:0] wr_channel_r,
  input wire logic [DATA_W-1:0] wr_data_r
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  property p_sda_low;
    sda_oe_r |-> !sda_out_r;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("ack drives sda high");
  property p_ack_mode;
    (!protocol_select) [*6] |-> !sda_oe_r;
  endproperty
  a_ack_mode: assert property (p_ack_mode)
    else $error("ack outside two-wire mode");
  property p_par_quiet;
    (!interface_select) [*6] |-> !rd_req_r && !sda_oe_r;
  endproperty
  a_par_quiet: assert property (p_par_quiet)
    else $error("serial activity in parallel mode");
  property p_rd_pulse;
    rd_req_r |=> !rd_req_r;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read request pulse too long");
  property p_wr_pulse;
    wr_valid_r |=> !wr_valid_r;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write pulse too long");
  property p_par_write;
    !interface_select && !cs_n && $rose(wr_n) |-> ##[2:4] wr_valid_r;
  endproperty
  a_par_write: assert property (p_par_write)
    else $error("strobe rise without write");
  property p_par_data;
    wr_valid_r && !interface_select |->
      wr_data_r == $past(data_field, 4) && wr_channel_r == $past(channel_address, 4);
  endproperty
  a_par_data: assert property (p_par_data)
    else $error("parallel word not carried straight");
  property p_toggle;
    wr_valid_r && (!interface_select || protocol_select) |-> !wr_toggle_b_r;
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle select outside four-wire");
  property p_sdo_idle;
    sync_n [*6] |-> !serial_data_out_r;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("readback output outside frame");
  c_read: cover property (rd_req_r);
  c_i2c_wr: cover property (wr_valid_r && protocol_select);
  c_ack: cover property ($rose(sda_oe_r));
endmodule // dhi_host_interface_properties
bind dhi_host_interface dhi_host_interface_properties #(.CH_W(CH_W), .DATA_W(DATA_W)) dhi_props_i (
  .ref_clk, .srst, .interface_select, .protocol_select, .sync_n, .cs_n, .wr_n,
  .channel_address, .data_field, .serial_data_out_r, .sda_out_r, .sda_oe_r,
  .rd_req_r, .wr_valid_r, .wr_toggle_b_r, .wr_channel_r, .wr_data_r);
`default_nettype wire

/* File: testbench/dhi_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dhi_host_model (
  input wire logic ref_clk,
  input wire logic serial_data_out,
  input wire logic sda_oe,
  output logic sclk = 1'b1,
  output logic sync_n = 1'b1,
  output logic din = 1'b0,
  output logic scl = 1'b1,
  output wire logic sda_in
);
  logic sda_drv = 1'b1;
  // Pull-up bus: low whenever either party pulls it
  assign sda_in = sda_drv & ~sda_oe;
  ////////////////////////////////////////
  // Clock idles high, so the first bit must come from the frame sync fall
  task automatic spi_frame(input logic [23:0] w, output logic [23:0] r);
    @(posedge ref_clk) #1;
    sync_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      din = w[i];
      #63 sclk = 1'b0;
      r[i] = serial_data_out;
      #62 sclk = 1'b1;
    end
    #64 sync_n = 1'b1;
    // Released data line must not look like a held bit
    din = ~din;
    #64;
  endtask
  ////////////////////////////////////////
  // Data moves only well after the clock fall, so no false start is seen
  task automatic i2c_bit(input logic b, output logic s);
    #12 sda_drv = b;
    #48 scl = 1'b1;
    s = sda_in;
    #64 scl = 1'b0;
  endtask
  task automatic i2c_start;
    @(posedge ref_clk) #1;
    #12 sda_drv = 1'b1;
    #48 scl = 1'b1;
    #32 sda_drv = 1'b0;
    #32 scl = 1'b0;
  endtask
  task automatic i2c_stop;
    #12 sda_drv = 1'b0;
    #48 scl = 1'b1;
    #32 sda_drv = 1'b1;
    #32;
  endtask
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    logic s;
    @(posedge ref_clk) #1;
    for (int i = 7; i >= 0; i--)
      i2c_bit(b[i], s);
    i2c_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule // dhi_host_model
`default_nettype wire

/* File: testbench/test_dhi_host_interface.sv */
`timescale 1ns/1ns
`default_nettype none
module test_dhi_host_interface;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic interface_select = 1'b1;
  logic protocol_select = 1'b0;
  logic cs_n = 1'b1;
  logic wr_n = 1'b1;
  logic [4:0] channel_address = 5'h09;
  logic register_select_high = 1'b1;
  logic register_select_low = 1'b0;
  logic [13:0] data_field = 14'h2a5c;
  logic address_strap_high = 1'b1;
  logic address_strap_low = 1'b0;
  wire logic sclk, sync_n, din, scl, sda_in;
  logic serial_data_out_r, sda_out_r, sda_oe_r, rd_req_r, wr_valid_r, wr_toggle_b_r;
  logic [4:0] rd_channel_r, wr_channel_r;
  logic [1:0] rd_reg_sel_r, wr_reg_sel_r;
  logic [13:0] rd_data, wr_data_r;
  int n_errors = 0;
  int cmp_count = 0;
  always #2 ref_clk = ~ref_clk;
  // Returned word encodes its own selection, so a wrong register shows
  assign rd_data = {rd_reg_sel_r, 7'h00, rd_channel_r};
  dhi_host_interface dhi_host_interface_i (.*);
  dhi_host_model dhi_host_model_i (.ref_clk, .serial_data_out(serial_data_out_r), .sda_oe(sda_oe_r),
    .sclk, .sync_n, .din, .scl, .sda_in);
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic ib(input logic [7:0] b, input logic e);
    logic a;
    dhi_host_model_i.i2c_byte(b, a);
    chk("ack", 24'(a), 24'(e));
  endtask
  function automatic logic [23:0] wr_word;
    return 24'({wr_channel_r, wr_reg_sel_r, wr_data_r});
  endfunction
  ////////////////////////////////////////
  task automatic t_spi;
    logic [23:0] r;
    logic [23:0] req;
    req = {3'b110, 5'h05, 2'h2, 14'h3abc};
    dhi_host_model_i.spi_frame(req, r);
    chk("rd sel", 24'({rd_channel_r, rd_reg_sel_r}), 24'h000016);
    dhi_host_model_i.spi_frame(24'h000000, r);
    chk("readback", r, {req[23:14], 2'h2, 7'h00, 5'h05});
    dhi_host_model_i.spi_frame({3'b100, 5'h1a, 2'h3, 14'h1234}, r);
    chk("spi wr", wr_word(), 24'({5'h1a, 2'h3, 14'h1234}));
    chk("spi toggle", 24'(wr_toggle_b_r), 24'h000001);
    $display("spi done");
  endtask
  task automatic t_i2c;
    protocol_select = 1'b1;
    repeat (8) @(posedge ref_clk);
    dhi_host_model_i.i2c_start();
    ib({5'h15, address_strap_high, address_strap_low, 1'b0}, 1'b1);
    ib(8'h03, 1'b1);
    ib(8'h40, 1'b1);
    ib(8'h12, 1'b1);
    chk("i2c wr", wr_word(), 24'({5'h03, 2'h1, 14'h0012}));
    ib(8'he4, 1'b1);
    ib(8'h8a, 1'b1);
    ib(8'hcd, 1'b1);
    chk("ptr wr", wr_word(), 24'({5'h04, 2'h2, 14'h0acd}));
    dhi_host_model_i.i2c_start();
    ib({5'h15, address_strap_high, address_strap_low, 1'b0}, 1'b1);
    ib(8'hff, 1'b1);
    for (int c = 0; c < 32; c++)
    begin
      ib({2'h3, c[5:0]}, 1'b1);
      ib(8'h5a, 1'b1);
      chk("burst", wr_word(), 24'({c[4:0], 2'h3, c[5:0], 8'h5a}));
    end
    ib(8'h07, 1'b1);
    ib(8'h41, 1'b1);
    ib(8'h00, 1'b1);
    chk("after burst", wr_word(), 24'({5'h07, 2'h1, 14'h0100}));
    dhi_host_model_i.i2c_stop();
    dhi_host_model_i.i2c_start();
    ib({5'h15, ~address_strap_high, address_strap_low, 1'b0}, 1'b0);
    dhi_host_model_i.i2c_stop();
    dhi_host_model_i.i2c_start();
    ib({5'h15, address_strap_high, address_strap_low, 1'b1}, 1'b0);
    dhi_host_model_i.i2c_stop();
    address_strap_low = 1'b1;
    dhi_host_model_i.i2c_start();
    ib(8'hae, 1'b1);
    dhi_host_model_i.i2c_stop();
    $display("i2c done");
  endtask
  task automatic par_pulse(input logic sel_n);
    @(posedge ref_clk) #1 cs_n = sel_n;
    wr_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 wr_n = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 cs_n = 1'b1;
  endtask
  task automatic t_par;
    interface_select = 1'b0;
    repeat (8) @(posedge ref_clk);
    par_pulse(1'b0);
    chk("par wr", wr_word(), 24'({5'h09, 2'h2, 14'h2a5c}));
    data_field = 14'h1111;
    par_pulse(1'b1);
    chk("deselected", wr_word(), 24'({5'h09, 2'h2, 14'h2a5c}));
    dhi_host_model_i.i2c_start();
    ib(8'hae, 1'b0);
    dhi_host_model_i.i2c_stop();
    $display("parallel done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1 srst = 1'b0;
    repeat (6) @(posedge ref_clk);
    t_spi();
    t_i2c();
    t_par();
    end_sim();
  end
  initial
  begin
    #300000;
    n_errors++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // test_dhi_host_interface
`default_nettype wire
